// ===== inc/fes_regs.svh
`ifndef FES_REGS_SVH
`define FES_REGS_SVH

// Hard fault status field layout
`define FES_HF_W 2
`define FES_HF_VECTOR_BIT 0
`define FES_HF_ESCAL_BIT 1

// Bus fault status field layout
`define FES_BF_W 5
`define FES_BF_STACK_BIT 0
`define FES_BF_UNSTACK_BIT 1
`define FES_BF_FETCH_BIT 2
`define FES_BF_EXACT_BIT 3
`define FES_BF_DEFER_BIT 4

// Usage fault status field layout
`define FES_UF_W 6
`define FES_UF_COPROC_BIT 0
`define FES_UF_OPCODE_BIT 1
`define FES_UF_STATE_BIT 2
`define FES_UF_RETCODE_BIT 3
`define FES_UF_MISALIGN_BIT 4
`define FES_UF_DIVZERO_BIT 5

// Memory management fault status layout
`define FES_MF_W 1
`define FES_MF_ACCESS_BIT 0

// Widths
`define FES_ADDR_W 32
`define FES_CFG_PRIO_W 8
`define FES_PRIO_W 10

// Reset values
`define FES_HF_RST 2'h0
`define FES_BF_RST 5'h00
`define FES_UF_RST 6'h00
`define FES_MF_RST 1'h0
`define FES_ADDR_RST 32'h0000_0000

// Priority limits, lower number is more urgent
`define FES_PRIO_THREAD 10'h100
`define FES_PRIO_PMASK 10'h000
`define FES_PRIO_FMASK 10'h3FF

`endif

// ===== inc/fes_pkg.sv
package fes_pkg;

   // Signed execution priority: hard fault -1, NMI -2, thread above 255
   typedef logic signed [9:0] fes_prio_t;

   // Exception class, one-hot
   typedef enum logic [5:0] {
      FES_EXC_NONE  = 6'h01,
      FES_EXC_MM    = 6'h02,
      FES_EXC_BUS   = 6'h04,
      FES_EXC_USAGE = 6'h08,
      FES_EXC_HARD  = 6'h10,
      FES_EXC_NMI   = 6'h20
   } fes_exc_t;

   // Sleep controller states
   typedef enum logic [2:0] {
      FES_ST_RUN = 3'h1,
      FES_ST_WFI = 3'h2,
      FES_ST_WFE = 3'h4
   } fes_sleep_st_t;

endpackage

// ===== core/fes_fault_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "fes_regs.svh"

module fes_fault_status
   import fes_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`FES_HF_W-1:0] hf_set,
   input wire logic [`FES_HF_W-1:0] hf_clr,
   input wire logic [`FES_BF_W-1:0] bf_set,
   input wire logic [`FES_BF_W-1:0] bf_clr,
   input wire logic [`FES_UF_W-1:0] uf_set,
   input wire logic [`FES_UF_W-1:0] uf_clr,
   input wire logic [`FES_MF_W-1:0] mf_set,
   input wire logic [`FES_MF_W-1:0] mf_clr,
   input wire logic bf_addr_load,
   input wire logic [`FES_ADDR_W-1:0] bf_addr_in,
   input wire logic mf_addr_load,
   input wire logic [`FES_ADDR_W-1:0] mf_addr_in,
   output logic [`FES_HF_W-1:0] hard_fault_status,
   output logic [`FES_BF_W-1:0] bus_fault_status,
   output logic [`FES_UF_W-1:0] usage_fault_status,
   output logic [`FES_MF_W-1:0] memmgmt_fault_status,
   output logic [`FES_ADDR_W-1:0] bus_fault_addr,
   output logic [`FES_ADDR_W-1:0] memmgmt_fault_addr
);

   // Sticky update; a set in the clear cycle wins so no event is lost
   function automatic logic [7:0] sticky(input logic [7:0] cur,
                                         input logic [7:0] set,
                                         input logic [7:0] clr);
      sticky = (cur & ~clr) | set;
   endfunction

   logic [7:0] hf_nxt;
   logic [7:0] bf_nxt;
   logic [7:0] uf_nxt;
   logic [7:0] mf_nxt;

   // Flags stay set until software clears them
   assign hf_nxt = sticky(8'(hard_fault_status), 8'(hf_set), 8'(hf_clr));
   assign bf_nxt = sticky(8'(bus_fault_status), 8'(bf_set), 8'(bf_clr));
   assign uf_nxt = sticky(8'(usage_fault_status), 8'(uf_set), 8'(uf_clr));
   assign mf_nxt = sticky(8'(memmgmt_fault_status), 8'(mf_set),
                          8'(mf_clr));

   // Status flag registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hard_fault_status <= `FES_HF_RST;
         bus_fault_status <= `FES_BF_RST;
         usage_fault_status <= `FES_UF_RST;
         memmgmt_fault_status <= `FES_MF_RST;
      end else begin
         hard_fault_status <= hf_nxt[`FES_HF_W-1:0];
         bus_fault_status <= bf_nxt[`FES_BF_W-1:0];
         usage_fault_status <= uf_nxt[`FES_UF_W-1:0];
         memmgmt_fault_status <= mf_nxt[`FES_MF_W-1:0];
      end
   end

   // Fault address capture, latest faulting access wins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_fault_addr <= `FES_ADDR_RST;
         memmgmt_fault_addr <= `FES_ADDR_RST;
      end else begin
         if (bf_addr_load) begin
            bus_fault_addr <= bf_addr_in;
         end
         if (mf_addr_load) begin
            memmgmt_fault_addr <= mf_addr_in;
         end
      end
   end

endmodule
`default_nettype wire

// ===== core/fes_sleep_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "fes_regs.svh"

module fes_sleep_ctrl
   import fes_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wfi_exec,
   input wire logic wfe_exec,
   input wire logic handler_exit_thread,
   input wire logic sleep_after_handler,
   input wire logic deep_sleep_select,
   input wire logic pending_wakes_event,
   input wire logic new_pend_irq,
   input wire logic ext_event,
   input wire logic entry_ok,
   input wire logic irq_wake_masked,
   input wire logic locked,
   output logic sleeping,
   output logic deep_sleep,
   output logic wfe_skip,
   output logic wake_pulse,
   output logic event_latch
);

   fes_sleep_st_t state_r;
   fes_sleep_st_t state_nxt;
   logic event_set;
   logic enter_wfi;
   logic enter_wfe;
   logic wake_wfi;
   logic wake_wfe;
   logic running;
   logic event_nxt;

   assign running = (state_r == FES_ST_RUN) && !locked;
   // Event sources; a new pend counts even if disabled
   assign event_set = ext_event || (pending_wakes_event && new_pend_irq);
   // Unconditional sleep, or sleep on handler exit
   assign enter_wfi = running &&
      (wfi_exec || (handler_exit_thread && sleep_after_handler));
   // Conditional sleep on an empty event latch
   assign enter_wfe = running && wfe_exec && !wfi_exec && !event_latch;
   assign wfe_skip = running && wfe_exec && !wfi_exec && event_latch;
   // Wakeup conditions
   assign wake_wfi = entry_ok || irq_wake_masked;
   assign wake_wfe = entry_ok || event_latch || event_set;
   assign wake_pulse = ((state_r == FES_ST_WFI) && wake_wfi) ||
                       ((state_r == FES_ST_WFE) && wake_wfe);
   assign sleeping = (state_r != FES_ST_RUN);

   // Next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         FES_ST_RUN: begin
            if (enter_wfi) begin
               state_nxt = FES_ST_WFI;
            end else if (enter_wfe) begin
               state_nxt = FES_ST_WFE;
            end
         end
         FES_ST_WFI: begin
            if (wake_wfi) begin
               state_nxt = FES_ST_RUN;
            end
         end
         FES_ST_WFE: begin
            if (wake_wfe) begin
               state_nxt = FES_ST_RUN;
            end
         end
         default: begin
            state_nxt = FES_ST_RUN;
         end
      endcase
   end

   // Latch consumed by a skipping WAIT_EVENT_INSTR or by an event wake
   always_comb begin
      event_nxt = event_latch || event_set;
      if (wfe_skip && !event_set) begin
         event_nxt = 1'b0;
      end else if ((state_r == FES_ST_WFE) && wake_wfe && !entry_ok) begin
         event_nxt = 1'b0;
      end
   end

   // State, event latch and sleep depth
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= FES_ST_RUN;
         event_latch <= 1'b0;
         deep_sleep <= 1'b0;
      end else begin
         state_r <= state_nxt;
         event_latch <= event_nxt;
         if (enter_wfi || enter_wfe) begin
            deep_sleep <= deep_sleep_select;
         end else if (state_nxt == FES_ST_RUN) begin
            deep_sleep <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ===== core/fes_fault_ctrl.sv
// Operation
// - Vector fetch bus error becomes hard fault and sets its flag
// - Any promotion of a configurable fault sets the escalated flag
// - Bus errors go to bus fault, one flag per error case
// - Usage faults set one flag per cause
// - Non-hard faults have programmable priority and enable each
// - A fault of the handler's own kind escalates to hard fault
// - Fault not above current priority escalates to hard fault
// - Fault whose handler is disabled escalates to hard fault
// - Stacking bus error entering bus fault handler does not escalate
// - Hard fault preempts all but reset, NMI and hard fault
// - Bus and memory management faults record the faulting address
// - Hard fault inside hard fault handler locks up until reset
// - Deep sleep select chooses the low-power mode at sleep entry
// - Wait-for-interrupt sleeps at once without any check
// - Wait-for-event sleeps if latch is 0, else clears and continues
// - With sleep after handler, handler exit to thread sleeps
// - Sleep ends on an exception with enough priority for entry
// - Interrupt mask set, fault mask clear: wake from wait-for-interrupt but defer handler
// - With pending wakes event, any new pend is an event
// - Enough priority means above every mask limit, else stays pending
`timescale 1ns/1ps
`default_nettype none
`include "fes_regs.svh"

module fes_fault_ctrl
   import fes_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   // Fault events from pipeline and bus interface, one-cycle pulses
   input wire logic vec_fetch_err,
   input wire logic hard_fault_req,
   input wire logic bus_err_stack,
   input wire logic bus_err_unstack,
   input wire logic bus_err_fetch,
   input wire logic bus_err_exact,
   input wire logic bus_err_deferred,
   input wire logic bus_entry_stacking,
   input wire logic bus_addr_valid,
   input wire logic [`FES_ADDR_W-1:0] bus_addr,
   input wire logic mm_fault,
   input wire logic mm_addr_valid,
   input wire logic [`FES_ADDR_W-1:0] mm_addr,
   input wire logic use_no_coproc,
   input wire logic use_bad_opcode,
   input wire logic use_bad_state,
   input wire logic use_bad_return,
   input wire logic use_misaligned,
   input wire logic use_zero_divisor,
   // Fault handler priority and enable configuration
   input wire logic [`FES_CFG_PRIO_W-1:0] mm_prio,
   input wire logic [`FES_CFG_PRIO_W-1:0] bus_prio,
   input wire logic [`FES_CFG_PRIO_W-1:0] usage_prio,
   input wire logic mm_handler_en,
   input wire logic bus_handler_en,
   input wire logic usage_handler_en,
   // Execution context from the prioritiser
   input wire fes_exc_t cur_exc,
   input wire fes_prio_t cur_prio,
   input wire logic interrupt_mask_bit,
   input wire logic fault_mask_bit,
   input wire logic pend_valid,
   input wire fes_prio_t pend_prio,
   input wire logic pend_is_irq,
   input wire logic pend_irq_en,
   input wire logic new_pend_irq,
   input wire logic ext_event,
   // Sleep control
   input wire logic wfi_exec,
   input wire logic wfe_exec,
   input wire logic handler_exit_thread,
   input wire logic sleep_after_handler,
   input wire logic deep_sleep_select,
   input wire logic pending_wakes_event,
   // Software clears, write one to clear
   input wire logic [`FES_HF_W-1:0] hf_clr,
   input wire logic [`FES_BF_W-1:0] bf_clr,
   input wire logic [`FES_UF_W-1:0] uf_clr,
   input wire logic [`FES_MF_W-1:0] mf_clr,
   // Fault routing to the prioritiser
   output logic fault_route_valid,
   output fes_exc_t fault_route,
   output logic hard_preempt,
   output logic entry_ok,
   output logic irq_deferred,
   output logic lockup,
   output logic core_halt,
   // Status and sleep
   output logic [`FES_HF_W-1:0] hard_fault_status,
   output logic [`FES_BF_W-1:0] bus_fault_status,
   output logic [`FES_UF_W-1:0] usage_fault_status,
   output logic [`FES_MF_W-1:0] memmgmt_fault_status,
   output logic [`FES_ADDR_W-1:0] bus_fault_addr,
   output logic [`FES_ADDR_W-1:0] memmgmt_fault_addr,
   output logic sleeping,
   output logic deep_sleep,
   output logic wfe_skip,
   output logic wake_pulse,
   output logic event_latch
);

   // Configured priority on the signed scale
   function automatic fes_prio_t cfg_prio(
      input logic [`FES_CFG_PRIO_W-1:0] p);
      cfg_prio = fes_prio_t'({2'h0, p});
   endfunction

   // Smaller of two signed priorities
   function automatic fes_prio_t prio_min(input fes_prio_t a,
                                          input fes_prio_t b);
      prio_min = (a < b) ? a : b;
   endfunction

   // Escalation test for one fault class
   function automatic logic must_escalate(input logic en,
                                          input fes_exc_t kind,
                                          input fes_prio_t p,
                                          input fes_exc_t running,
                                          input fes_prio_t limit);
      logic disabled;
      logic same_kind;
      logic not_above;
      disabled = !en;
      same_kind = (running == kind);
      not_above = (p >= limit);
      must_escalate = disabled || same_kind || not_above;
   endfunction

   fes_prio_t eff_prio;
   fes_prio_t pm_limit;
   logic [`FES_BF_W-1:0] bf_ev;
   logic [`FES_UF_W-1:0] uf_ev;
   logic bus_any;
   logic usage_any;
   logic bus_stack_exempt;
   logic mm_esc;
   logic bus_esc;
   logic usage_esc;
   logic any_esc;
   logic hard_src;
   logic hard_in_hard;
   logic mm_route;
   logic bus_route;
   logic usage_route;
   logic route_any;
   fes_exc_t route_kind;
   logic [`FES_HF_W-1:0] hf_set;
   logic [`FES_BF_W-1:0] bf_set;
   logic [`FES_UF_W-1:0] uf_set;
   logic [`FES_MF_W-1:0] mf_set;
   logic irq_wake_masked;
   logic lockup_r;
   logic route_valid_r;
   fes_exc_t route_r;
   logic hard_preempt_r;

   // Limit from current level and masks
   assign pm_limit = interrupt_mask_bit ?
      prio_min(cur_prio, fes_prio_t'(`FES_PRIO_PMASK)) : cur_prio;
   assign eff_prio = fault_mask_bit ?
      prio_min(pm_limit, fes_prio_t'(`FES_PRIO_FMASK)) : pm_limit;

   // Exception entry needs priority above every mask limit
   assign entry_ok = pend_valid && (pend_prio < eff_prio);
   // Masked irq wakes from WFI sleep but is held back
   assign irq_wake_masked = interrupt_mask_bit && !fault_mask_bit &&
      pend_valid && pend_is_irq && pend_irq_en && (pend_prio < cur_prio);
   assign irq_deferred = irq_wake_masked && !entry_ok;

   // Event vectors in status field order
   assign bf_ev[`FES_BF_STACK_BIT] = bus_err_stack;
   assign bf_ev[`FES_BF_UNSTACK_BIT] = bus_err_unstack;
   assign bf_ev[`FES_BF_FETCH_BIT] = bus_err_fetch;
   assign bf_ev[`FES_BF_EXACT_BIT] = bus_err_exact;
   assign bf_ev[`FES_BF_DEFER_BIT] = bus_err_deferred;
   assign uf_ev[`FES_UF_COPROC_BIT] = use_no_coproc;
   assign uf_ev[`FES_UF_OPCODE_BIT] = use_bad_opcode;
   assign uf_ev[`FES_UF_STATE_BIT] = use_bad_state;
   assign uf_ev[`FES_UF_RETCODE_BIT] = use_bad_return;
   assign uf_ev[`FES_UF_MISALIGN_BIT] = use_misaligned;
   assign uf_ev[`FES_UF_DIVZERO_BIT] = use_zero_divisor;
   assign bus_any = |bf_ev;
   assign usage_any = |uf_ev;

   // Stacking error entering bus handler
   assign bus_stack_exempt = bus_err_stack && bus_entry_stacking &&
      !(bus_err_unstack || bus_err_fetch || bus_err_exact ||
        bus_err_deferred);

   // Escalation per class using the programmed priorities
   assign mm_esc = mm_fault && must_escalate(mm_handler_en, FES_EXC_MM,
      cfg_prio(mm_prio), cur_exc, eff_prio);
   assign bus_esc = bus_any && !bus_stack_exempt &&
      must_escalate(bus_handler_en, FES_EXC_BUS, cfg_prio(bus_prio),
                    cur_exc, eff_prio);
   assign usage_esc = usage_any && must_escalate(usage_handler_en,
      FES_EXC_USAGE, cfg_prio(usage_prio), cur_exc, eff_prio);
   assign any_esc = mm_esc || bus_esc || usage_esc;

   // Hard fault sources; vector fetch error is always hard
   assign hard_src = (vec_fetch_err || hard_fault_req || any_esc) &&
      !lockup_r;
   // Hard fault in hard handler locks
   assign hard_in_hard = hard_src && (cur_exc == FES_EXC_HARD);

   // Non-escalated faults go to their own handler
   assign mm_route = mm_fault && !mm_esc;
   assign bus_route = bus_any && !bus_esc;
   assign usage_route = usage_any && !usage_esc;
   assign route_any = !lockup_r && !hard_in_hard &&
      (hard_src || mm_route || bus_route || usage_route);

   // Hard first, then most urgent fault
   always_comb begin
      route_kind = FES_EXC_NONE;
      if (hard_src) begin
         route_kind = FES_EXC_HARD;
      end else if (mm_route && (!bus_route ||
                   cfg_prio(mm_prio) <= cfg_prio(bus_prio)) &&
                   (!usage_route ||
                   cfg_prio(mm_prio) <= cfg_prio(usage_prio))) begin
         route_kind = FES_EXC_MM;
      end else if (bus_route && (!usage_route ||
                   cfg_prio(bus_prio) <= cfg_prio(usage_prio))) begin
         route_kind = FES_EXC_BUS;
      end else if (usage_route) begin
         route_kind = FES_EXC_USAGE;
      end
   end

   // Status flag sets
   assign hf_set[`FES_HF_VECTOR_BIT] = vec_fetch_err;
   assign hf_set[`FES_HF_ESCAL_BIT] = any_esc;
   assign bf_set = bf_ev;
   assign uf_set = uf_ev;
   assign mf_set[`FES_MF_ACCESS_BIT] = mm_fault;

   // Sticky flags and fault address registers
   fes_fault_status u_status (
      .clk(clk),
      .sys_rst(sys_rst),
      .hf_set(hf_set),
      .hf_clr(hf_clr),
      .bf_set(bf_set),
      .bf_clr(bf_clr),
      .uf_set(uf_set),
      .uf_clr(uf_clr),
      .mf_set(mf_set),
      .mf_clr(mf_clr),
      .bf_addr_load(bus_any && bus_addr_valid),
      .bf_addr_in(bus_addr),
      .mf_addr_load(mm_fault && mm_addr_valid),
      .mf_addr_in(mm_addr),
      .hard_fault_status(hard_fault_status),
      .bus_fault_status(bus_fault_status),
      .usage_fault_status(usage_fault_status),
      .memmgmt_fault_status(memmgmt_fault_status),
      .bus_fault_addr(bus_fault_addr),
      .memmgmt_fault_addr(memmgmt_fault_addr)
   );

   // Sleep entry and wakeup
   fes_sleep_ctrl u_sleep (
      .clk(clk),
      .sys_rst(sys_rst),
      .wfi_exec(wfi_exec),
      .wfe_exec(wfe_exec),
      .handler_exit_thread(handler_exit_thread),
      .sleep_after_handler(sleep_after_handler),
      .deep_sleep_select(deep_sleep_select),
      .pending_wakes_event(pending_wakes_event),
      .new_pend_irq(new_pend_irq),
      .ext_event(ext_event),
      .entry_ok(entry_ok),
      .irq_wake_masked(irq_wake_masked),
      .locked(lockup_r),
      .sleeping(sleeping),
      .deep_sleep(deep_sleep),
      .wfe_skip(wfe_skip),
      .wake_pulse(wake_pulse),
      .event_latch(event_latch)
   );

   // Lockup holds until reset; nothing else clears it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lockup_r <= 1'b0;
      end else if (hard_in_hard) begin
         lockup_r <= 1'b1;
      end
   end

   // Registered routing, one cycle per event
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         route_valid_r <= 1'b0;
         route_r <= FES_EXC_NONE;
         hard_preempt_r <= 1'b0;
      end else begin
         route_valid_r <= route_any;
         route_r <= route_any ? route_kind : FES_EXC_NONE;
         // NMI, a running hard fault (which locks up instead) and reset hold off hard fault
         hard_preempt_r <= route_any && (route_kind == FES_EXC_HARD) &&
            (cur_exc != FES_EXC_NMI);
      end
   end

   assign fault_route_valid = route_valid_r;
   assign fault_route = route_r;
   assign hard_preempt = hard_preempt_r;
   assign lockup = lockup_r;
   // Lockup stops instruction execution, as does sleep
   assign core_halt = lockup_r || sleeping;

endmodule
`default_nettype wire

// ===== bench/fes_fault_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fes_ctrl_chk
   import fes_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic vec_fetch_err,
   input wire logic hard_fault_req,
   input wire logic bus_err_exact,
   input wire logic use_zero_divisor,
   input wire logic [5:0] uf_clr,
   input wire fes_exc_t cur_exc,
   input wire logic wfi_exec,
   input wire logic wfe_exec,
   input wire logic [1:0] hard_fault_status,
   input wire logic [4:0] bus_fault_status,
   input wire logic [5:0] usage_fault_status,
   input wire logic lockup,
   input wire logic core_halt,
   input wire logic sleeping,
   input wire logic wfe_skip,
   input wire logic wake_pulse,
   input wire logic event_latch
);
   // One clock domain
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_divzero_flag: assert property (use_zero_divisor
      |=> usage_fault_status[5]) else $error("no divzero flag");
   a_exact_flag: assert property (bus_err_exact
      |=> bus_fault_status[3]) else $error("no exact flag");
   a_vector_flag: assert property (vec_fetch_err
      |=> hard_fault_status[0]) else $error("no vector flag");
   a_flag_sticky: assert property ($fell(usage_fault_status[5])
      |-> $past(uf_clr[5])) else $error("flag dropped");
   a_lock_entry: assert property (hard_fault_req
      && cur_exc == FES_EXC_HARD |=> lockup) else $error("no lockup");
   a_lock_hold: assert property (lockup
      |=> lockup && core_halt) else $error("lockup left");
   a_wfi_sleep: assert property (wfi_exec && !sleeping
      && !lockup |=> sleeping) else $error("no wfi sleep");
   a_wfe_check: assert property (wfe_exec && !wfi_exec
      && !sleeping && !lockup |=> sleeping == !$past(event_latch))
      else $error("wfe test wrong");
   a_wfe_skip: assert property (wfe_exec && !wfi_exec
      && event_latch && !sleeping && !lockup |-> wfe_skip)
      else $error("no skip");
   a_wake_drop: assert property (sleeping && wake_pulse
      |=> !sleeping) else $error("still asleep");
   // Scenarios
   c_lockup: cover property (lockup);
   c_wake: cover property (sleeping && wake_pulse);
   c_skip: cover property (wfe_skip);
endmodule
bind fes_fault_ctrl fes_ctrl_chk u_chk (.*);
`default_nettype wire

// ===== bench/fes_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module fes_core_model
   import fes_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ret,
   input wire logic fault_route_valid,
   input wire fes_exc_t fault_route,
   input wire logic [7:0] bus_prio,
   input wire logic [7:0] usage_prio,
   output var fes_exc_t cur_exc,
   output var fes_prio_t cur_prio
);
   // Enters routed faults; return wins a clash
   always_ff @(posedge clk) begin
      if (sys_rst || ret) begin
         cur_exc <= FES_EXC_NONE;
         cur_prio <= 10'h100;
      end else if (fault_route_valid) begin
         cur_exc <= fault_route;
         cur_prio <= fault_route == FES_EXC_HARD ? 10'h3FF :
            {2'h0, fault_route == FES_EXC_BUS ? bus_prio : usage_prio};
      end
   end
endmodule
`default_nettype wire

// ===== bench/fault_escalation_sleep_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fault_escalation_sleep_ctrl_bench
   import fes_pkg::*;
;
   logic clk = 0, sys_rst = 1, ret = 0, vec_fetch_err = 0, hard_fault_req = 0;
   logic bus_entry_stacking = 0, bus_addr_valid = 0, mm_fault = 0;
   logic mm_addr_valid = 0, mm_handler_en = 1, bus_handler_en = 1;
   logic usage_handler_en = 1, interrupt_mask_bit = 0, fault_mask_bit = 0;
   logic pend_valid = 0, pend_is_irq = 0, pend_irq_en = 0, new_pend_irq = 0;
   logic ext_event = 0, wfi_exec = 0, wfe_exec = 0, handler_exit_thread = 0;
   logic sleep_after_handler = 0, deep_sleep_select = 0;
   logic pending_wakes_event = 0;
   logic [31:0] bus_addr = 0, mm_addr = 0, bus_fault_addr, memmgmt_fault_addr;
   logic [7:0] mm_prio = 8'h02, bus_prio = 8'h02, usage_prio = 8'h04;
   fes_prio_t pend_prio = 10'h020, cur_prio;
   logic [1:0] hf_clr = 0, hard_fault_status;
   logic [4:0] bf_clr = 0, bus_fault_status, bus_v = 0;
   logic [5:0] uf_clr = 0, usage_fault_status, use_v = 0;
   logic [0:0] mf_clr = 0, memmgmt_fault_status;
   fes_exc_t cur_exc, fault_route;
   logic fault_route_valid, hard_preempt, entry_ok, irq_deferred, lockup;
   logic core_halt, sleeping, deep_sleep, wfe_skip, wake_pulse, event_latch;
   int errors = 0, cmp_count = 0, cyc = 0;
   // One-hot fault cause vectors
   wire logic use_no_coproc = use_v[0], use_bad_opcode = use_v[1],
      use_bad_state = use_v[2], use_bad_return = use_v[3],
      use_misaligned = use_v[4], use_zero_divisor = use_v[5];
   wire logic bus_err_stack = bus_v[0], bus_err_unstack = bus_v[1],
      bus_err_fetch = bus_v[2], bus_err_exact = bus_v[3],
      bus_err_deferred = bus_v[4];
   fes_fault_ctrl dut (.*);
   fes_core_model core (.*);
   initial forever #4 clk = ~clk;
   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tick(int n = 1);
      repeat (n) @(negedge clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      tick();
      s = 0;
   endtask
   // Wake held one cycle
   task automatic wake(ref logic s);
      s = 1;
      #2;
      chk(32'(wake_pulse), 32'h1);
      tick();
      s = 0;
      chk(32'(sleeping), 32'h0);
   endtask
   task automatic usage_walk();
      for (int i = 0; i < 6; i++) begin
         use_v = 6'h01 << i;
         tick();
         use_v = 6'h00;
         chk(32'(usage_fault_status[i]), 32'h1);
         chk(32'(fault_route), 32'(FES_EXC_USAGE));
         pulse(ret);
      end
      chk(32'(usage_fault_status), 32'h3F);
   endtask
   task automatic bus_walk();
      bus_addr_valid = 1;
      for (int i = 0; i < 5; i++) begin
         bus_v = 5'h01 << i;
         bus_addr = 32'h2000_0000 + 32'(i);
         tick();
         bus_v = 5'h00;
         chk(32'(bus_fault_status[i]), 32'h1);
         chk(bus_fault_addr, 32'h2000_0000 + 32'(i));
         pulse(ret);
      end
      mm_addr_valid = 1;
      mm_addr = 32'h3000_0040;
      pulse(mm_fault);
      chk(memmgmt_fault_addr | 32'(memmgmt_fault_status),
         32'h3000_0041);
      pulse(ret);
   endtask
   // Faults inside handlers and with the usage handler disabled, then clears
   task automatic escalate();
      bus_v = 5'h08;
      tick(2);
      bus_v = 5'h01;
      bus_entry_stacking = 1;
      tick();
      bus_v = 5'h00;
      chk(32'(fault_route), 32'(FES_EXC_BUS));
      tick();
      use_v = 6'h01;
      tick();
      use_v = 6'h00;
      chk(32'(fault_route), 32'(FES_EXC_HARD));
      chk(32'(hard_fault_status), 32'h2);
      pulse(ret);
      use_v = 6'h02;
      tick(2);
      use_v = 6'h04;
      tick();
      use_v = 6'h00;
      chk(32'(fault_route), 32'(FES_EXC_HARD));
      pulse(ret);
      usage_handler_en = 0;
      use_v = 6'h08;
      tick();
      use_v = 6'h00;
      usage_handler_en = 1;
      chk(32'(fault_route), 32'(FES_EXC_HARD));
      pulse(ret);
      hf_clr = 2'h3;
      uf_clr = 6'h3F;
      tick();
      hf_clr = 2'h0;
      uf_clr = 6'h00;
      chk(32'({hard_fault_status, usage_fault_status}), 32'h0);
   endtask
   task automatic sleep_walk();
      deep_sleep_select = 1;
      pulse(wfi_exec);
      chk(32'({sleeping, deep_sleep, core_halt}), 32'h7);
      wake(pend_valid);
      sleep_after_handler = 1;
      deep_sleep_select = 0;
      pulse(handler_exit_thread);
      chk(32'({sleeping, deep_sleep}), 32'h2);
      wake(pend_valid);
      interrupt_mask_bit = 1;
      pend_is_irq = 1;
      pend_irq_en = 1;
      pulse(wfi_exec);
      pend_valid = 1;
      #2;
      chk(32'({wake_pulse, entry_ok, irq_deferred}), 32'h5);
      tick();
      pend_valid = 0;
      chk(32'(sleeping), 32'h0);
   endtask
   task automatic wfe_walk();
      pulse(ext_event);
      chk(32'(event_latch), 32'h1);
      wfe_exec = 1;
      #2;
      chk(32'(wfe_skip), 32'h1);
      tick();
      wfe_exec = 0;
      chk(32'({sleeping, event_latch}), 32'h0);
      pulse(wfe_exec);
      chk(32'(sleeping), 32'h1);
      pending_wakes_event = 1;
      wake(new_pend_irq);
   endtask
   task automatic lockup_reset();
      pulse(vec_fetch_err);
      chk(32'({fault_route, hard_fault_status[0]}), 32'h21);
      chk(32'(hard_preempt), 32'h1);
      tick();
      pulse(hard_fault_req);
      chk(32'({lockup, core_halt}), 32'h3);
      use_v = 6'h01;
      tick();
      use_v = 6'h00;
      chk(32'({fault_route_valid, lockup}), 32'h1);
      sys_rst = 1;
      tick(2);
      sys_rst = 0;
      chk(32'({lockup, hard_fault_status}), 32'h0);
   endtask
   initial begin
      tick(6);
      sys_rst = 0;
      usage_walk();
      bus_walk();
      escalate();
      sleep_walk();
      wfe_walk();
      lockup_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
